// >>> include/scs_consts.svh
// register offsets, field positions, reset values and timing constants of the clock select block
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SCS_ADDR_W            8
`define SCS_OFF_INT_OSC       8'h00
`define SCS_OFF_EXT_OSC       8'h04
`define SCS_OFF_CLK_SEL       8'h08
`define SCS_OFF_IRQ_STATUS    8'h0C
`define SCS_OFF_IRQ_CLEAR     8'h10
`define SCS_OFF_IRQ_ENABLE    8'h14
`define SCS_OFF_STATE         8'h18

// ************************************************************
// field positions
// ************************************************************
`define SCS_INT_EN_BIT        7
`define SCS_SEL_BIT           0
`define SCS_MODE_LSB          4
`define SCS_MODE_MSB          6
`define SCS_FREQ_LSB          0
`define SCS_FREQ_MSB          2
`define SCS_VALID_BIT         7
`define SCS_IRQ_VALID_BIT     0
`define SCS_IRQ_LOST_BIT      1
`define SCS_IRQ_SWITCH_BIT    2
`define SCS_IRQ_W             3

// ************************************************************
// reset values
// ************************************************************
`define SCS_INT_OSC_RST       8'h80
`define SCS_EXT_OSC_RST       8'h00
`define SCS_CLK_SEL_RST       1'b0

// ************************************************************
// timing: settle time of a crystal in microseconds, clock in MHz
// ************************************************************
`define SCS_CRYSTAL_SETTLE_US 1000
`define SCS_CLK_MHZ           250
`define SCS_CRYSTAL_CYCLES    (`SCS_CRYSTAL_SETTLE_US * `SCS_CLK_MHZ)
`define SCS_SYNC_STAGES       2

// axi response codes
`define SCS_RESP_OKAY         2'b00
`define SCS_RESP_SLVERR       2'b10

`endif

// >>> include/scs_pkg.sv
// types shared by the clock select block
package scs_pkg;

  // external oscillator mode field, values as software writes them
  typedef enum logic [2:0] {
    SCS_EXT_OFF     = 3'h0,
    SCS_EXT_CMOS    = 3'h2,
    SCS_EXT_RC      = 3'h4,
    SCS_EXT_CAP     = 3'h5,
    SCS_EXT_CRYSTAL = 3'h6,
    SCS_EXT_RESON   = 3'h7
  } scs_ext_mode_t;

  // settle tracker states, gray coded along off, settling, valid
  typedef enum logic [1:0] {
    SCS_ST_OFF      = 2'b00,
    SCS_ST_SETTLING = 2'b01,
    SCS_ST_VALID    = 2'b11
  } scs_settle_state_t;

endpackage : scs_pkg

// >>> include/scs_osc_if.sv
// control and status carried between the register core and the settle tracker
`timescale 1ns/100ps
interface scs_osc_if;
  logic                   ext_enable;
  logic                   needs_settle;
  logic                   osc_alive;
  logic                   crystal_valid_flag;
  logic                   valid_rise;
  logic                   valid_lost;

  modport core (
    output ext_enable,
    output needs_settle,
    input  crystal_valid_flag,
    input  valid_rise,
    input  valid_lost
  );

  modport tracker (
    input  ext_enable,
    input  needs_settle,
    input  osc_alive,
    output crystal_valid_flag,
    output valid_rise,
    output valid_lost
  );

  modport pin (
    output osc_alive
  );
endinterface : scs_osc_if

// >>> core/scs_sync.sv
// two-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/100ps
module scs_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  // first stage feeds only the second
  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (!aresetn) begin
      nxt_meta = 1'b0;
      nxt_sync = 1'b0;
    end else if (ce) begin
      nxt_meta = din;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge aclk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign dout = sync_ff;

endmodule : scs_sync

// >>> core/scs_settle.sv
// settle tracker for the external oscillator: counts a start-up interval in crystal modes
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_settle #(
  parameter int unsigned SETTLE_CYCLES = `SCS_CRYSTAL_CYCLES
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  ce,
  scs_osc_if.tracker osc
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  scs_pkg::scs_settle_state_t state_ff;
  scs_pkg::scs_settle_state_t nxt_state;
  logic [CW-1:0]              cnt_ff;
  logic [CW-1:0]              nxt_cnt;
  logic                       rise_ff;
  logic                       nxt_rise;
  logic                       lost_ff;
  logic                       nxt_lost;

  // valid needs the source enabled, oscillating, and in crystal modes a full settle count
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rise  = 1'b0;
    nxt_lost  = 1'b0;
    if (!aresetn) begin
      nxt_state = scs_pkg::SCS_ST_OFF;
      nxt_cnt   = '0;
    end else if (ce) begin
      case (state_ff)
        scs_pkg::SCS_ST_OFF: begin
          nxt_cnt = '0;
          if (osc.ext_enable && osc.osc_alive) begin
            if (osc.needs_settle) begin
              nxt_state = scs_pkg::SCS_ST_SETTLING;
            end else begin
              nxt_state = scs_pkg::SCS_ST_VALID;     // rc and capacitor usable at once
              nxt_rise  = 1'b1;
            end
          end
        end
        scs_pkg::SCS_ST_SETTLING: begin
          if (!osc.ext_enable || !osc.osc_alive) begin
            nxt_state = scs_pkg::SCS_ST_OFF;
          end else if (!osc.needs_settle || cnt_ff == CW'(SETTLE_CYCLES - 1)) begin
            nxt_state = scs_pkg::SCS_ST_VALID;       // settled, flag set
            nxt_rise  = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + CW'(1);
          end
        end
        scs_pkg::SCS_ST_VALID: begin
          if (!osc.ext_enable || !osc.osc_alive) begin
            nxt_state = scs_pkg::SCS_ST_OFF;         // disabled reads zero
            nxt_lost  = osc.ext_enable;
          end
        end
        default: nxt_state = scs_pkg::SCS_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    state_ff <= nxt_state;
    cnt_ff   <= nxt_cnt;
    rise_ff  <= nxt_rise;
    lost_ff  <= nxt_lost;
  end

  assign osc.crystal_valid_flag = (state_ff == scs_pkg::SCS_ST_VALID);
  assign osc.valid_rise         = rise_ff;
  assign osc.valid_lost         = lost_ff;

endmodule : scs_settle

// >>> core/scs_clock_select.sv
// system clock source selection with axi4-lite registers
//
// Operation
// - external drives system clock once select is one, and keeps it while internal is off
// - external enable stays on for peripherals anytime
// - switch only to an enabled, settled source
// - internal enable and select take separate writes to separate registers
// - hardware sets crystal valid flag when settled
// - rc and capacitor modes valid at once
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_clock_select #(
  parameter int unsigned SETTLE_CYCLES = `SCS_CRYSTAL_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // oscillator pins and clock control
  input  wire logic        ext_osc_running,
  output logic             int_osc_enable,
  output logic             ext_osc_enable,
  output logic [2:0]       ext_osc_mode,
  output logic [2:0]       external_freq_control_bits,
  output logic             sysclk_use_external,
  output logic             periph_ext_clock_enable,
  output logic             irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic        aw_hold_ff, nxt_aw_hold;
  logic [7:0]  aw_addr_ff, nxt_aw_addr;
  logic        w_hold_ff, nxt_w_hold;
  logic [31:0] w_data_ff, nxt_w_data;
  logic        w_lane_ff, nxt_w_lane;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [7:0]  int_osc_ff, nxt_int_osc;
  logic [7:0]  ext_osc_ff, nxt_ext_osc;
  logic        clk_sel_ff, nxt_clk_sel;
  logic [`SCS_IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [`SCS_IRQ_W-1:0] irq_en_ff, nxt_irq_en;
  logic        irq_ff, nxt_irq;
  logic        use_ext_ff, nxt_use_ext;
  logic        osc_alive_sync;

  scs_osc_if osc ();

  // ************************************************************
  // oscillator pin and settle tracker
  // ************************************************************
  scs_sync u_alive_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (ext_osc_running),
    .dout    (osc_alive_sync)
  );
  assign osc.osc_alive = osc_alive_sync;

  scs_settle #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .osc     (osc.tracker)
  );

  // mode off disables the external circuit; crystal and resonator need the settle count
  assign osc.ext_enable   = (ext_osc_ff[`SCS_MODE_MSB:`SCS_MODE_LSB] != scs_pkg::SCS_EXT_OFF);
  assign osc.needs_settle = (ext_osc_ff[`SCS_MODE_MSB:`SCS_MODE_LSB] == scs_pkg::SCS_EXT_CRYSTAL) ||
                            (ext_osc_ff[`SCS_MODE_MSB:`SCS_MODE_LSB] == scs_pkg::SCS_EXT_RESON);

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;

  // address and data are taken in either order; the write commits once both are held or offered
  assign wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
  assign wr_lane = w_hold_ff ? w_lane_ff : s_axi_wstrb[0];
  assign wr_fire = ce && !bvalid_ff && (aw_hold_ff || s_axi_awvalid) && (w_hold_ff || s_axi_wvalid);
  assign rd_fire = ce && !rvalid_ff && s_axi_arvalid;

  always_comb begin
    wr_hit = 1'b1;
    case (wr_addr)
      `SCS_OFF_INT_OSC, `SCS_OFF_EXT_OSC, `SCS_OFF_CLK_SEL,
      `SCS_OFF_IRQ_CLEAR, `SCS_OFF_IRQ_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // read mux: the valid flag is folded in from hardware, never stored
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `SCS_OFF_INT_OSC:    rd_word[7:0] = int_osc_ff;
      `SCS_OFF_EXT_OSC: begin
        rd_word[7:0] = ext_osc_ff;
        rd_word[`SCS_VALID_BIT] = osc.crystal_valid_flag;
      end
      `SCS_OFF_CLK_SEL:    rd_word[`SCS_SEL_BIT] = clk_sel_ff;
      `SCS_OFF_IRQ_STATUS: rd_word[`SCS_IRQ_W-1:0] = irq_stat_ff;
      `SCS_OFF_IRQ_CLEAR:  rd_word = 32'h0000_0000;             // write-only
      `SCS_OFF_IRQ_ENABLE: rd_word[`SCS_IRQ_W-1:0] = irq_en_ff;
      `SCS_OFF_STATE: begin
        rd_word[0] = use_ext_ff;
        rd_word[1] = osc.ext_enable;
        rd_word[2] = int_osc_ff[`SCS_INT_EN_BIT];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // bus handshake registers
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_lane  = w_lane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (!aresetn) begin
      nxt_aw_hold = 1'b0;
      nxt_aw_addr = 8'h00;
      nxt_w_hold  = 1'b0;
      nxt_w_data  = 32'h0000_0000;
      nxt_w_lane  = 1'b0;
      nxt_bvalid  = 1'b0;
      nxt_bresp   = `SCS_RESP_OKAY;
      nxt_rvalid  = 1'b0;
      nxt_rdata   = 32'h0000_0000;
      nxt_rresp   = `SCS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        nxt_aw_hold = 1'b1;
        nxt_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        nxt_w_hold = 1'b1;
        nxt_w_data = s_axi_wdata;
        nxt_w_lane = s_axi_wstrb[0];
      end
      if (wr_fire) begin
        nxt_aw_hold = 1'b0;
        nxt_w_hold  = 1'b0;
        nxt_bvalid  = 1'b1;
        nxt_bresp   = wr_hit ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        nxt_bvalid = 1'b0;
      end
      if (rd_fire) begin
        nxt_rvalid = 1'b1;
        nxt_rdata  = rd_word;
        nxt_rresp  = rd_hit ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        nxt_rvalid = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    aw_hold_ff <= nxt_aw_hold;
    aw_addr_ff <= nxt_aw_addr;
    w_hold_ff  <= nxt_w_hold;
    w_data_ff  <= nxt_w_data;
    w_lane_ff  <= nxt_w_lane;
    bvalid_ff  <= nxt_bvalid;
    bresp_ff   <= nxt_bresp;
    rvalid_ff  <= nxt_rvalid;
    rdata_ff   <= nxt_rdata;
    rresp_ff   <= nxt_rresp;
  end

  // ready is only offered when the slot is free and no response is pending
  assign s_axi_awready = aresetn && ce && !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = aresetn && ce && !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = aresetn && ce && !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // ************************************************************
  // control registers, clock steering and interrupts
  // ************************************************************
  logic [`SCS_IRQ_W-1:0] irq_events;
  logic                  switch_event;

  // a completed switch of the system clock source is reported as an event
  assign switch_event = (nxt_use_ext != use_ext_ff) && aresetn && ce;
  assign irq_events   = {switch_event, osc.valid_lost, osc.valid_rise};

  always_comb begin
    nxt_int_osc  = int_osc_ff;
    nxt_ext_osc  = ext_osc_ff;
    nxt_clk_sel  = clk_sel_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_en   = irq_en_ff;
    nxt_irq      = irq_ff;
    if (!aresetn) begin
      nxt_int_osc  = `SCS_INT_OSC_RST;
      nxt_ext_osc  = `SCS_EXT_OSC_RST;
      nxt_clk_sel  = `SCS_CLK_SEL_RST;
      nxt_irq_stat = '0;
      nxt_irq_en   = '0;
      nxt_irq      = 1'b0;
    end else if (ce) begin
      if (wr_fire && wr_lane) begin
        case (wr_addr)
          // internal enable in bit seven lands one cycle after the write
          `SCS_OFF_INT_OSC:    nxt_int_osc = wr_data[7:0];
          // mode and frequency as software programs them, valid bit not writable
          `SCS_OFF_EXT_OSC:    nxt_ext_osc = {1'b0, wr_data[6:0]};
          `SCS_OFF_CLK_SEL:    nxt_clk_sel = wr_data[`SCS_SEL_BIT];
          `SCS_OFF_IRQ_CLEAR:  nxt_irq_stat = irq_stat_ff & ~wr_data[`SCS_IRQ_W-1:0];
          `SCS_OFF_IRQ_ENABLE: nxt_irq_en = wr_data[`SCS_IRQ_W-1:0];
          default: ;
        endcase
      end
      // set wins over a clear in the same cycle
      nxt_irq_stat = nxt_irq_stat | irq_events;
      nxt_irq      = |(irq_stat_ff & irq_en_ff);
    end
  end

  // steering apart, so the switch event may read its next value
  always_comb begin
    nxt_use_ext = use_ext_ff;
    if (!aresetn) begin
      nxt_use_ext = 1'b0;
    end else if (ce) begin
      // the switch only follows when the newly chosen source is running and settled
      if (clk_sel_ff && osc.crystal_valid_flag) begin
        nxt_use_ext = 1'b1;
      end else if (!clk_sel_ff && int_osc_ff[`SCS_INT_EN_BIT]) begin
        nxt_use_ext = 1'b0;
      end else if (use_ext_ff && !osc.crystal_valid_flag && int_osc_ff[`SCS_INT_EN_BIT]) begin
        nxt_use_ext = 1'b0;                                     // fall back if external dies
      end
    end
  end

  always_ff @(posedge aclk) begin
    int_osc_ff  <= nxt_int_osc;
    ext_osc_ff  <= nxt_ext_osc;
    clk_sel_ff  <= nxt_clk_sel;
    irq_stat_ff <= nxt_irq_stat;
    irq_en_ff   <= nxt_irq_en;
    irq_ff      <= nxt_irq;
    use_ext_ff  <= nxt_use_ext;
  end

  // outputs straight from registers
  assign int_osc_enable             = int_osc_ff[`SCS_INT_EN_BIT];
  assign ext_osc_enable             = ext_osc_ff[`SCS_MODE_MSB:`SCS_MODE_LSB] != 3'h0;
  assign ext_osc_mode               = ext_osc_ff[`SCS_MODE_MSB:`SCS_MODE_LSB];
  assign external_freq_control_bits = ext_osc_ff[`SCS_FREQ_MSB:`SCS_FREQ_LSB];
  assign sysclk_use_external        = use_ext_ff;
  assign periph_ext_clock_enable    = osc.crystal_valid_flag;   // independent of select
  assign irq                        = irq_ff;

endmodule : scs_clock_select

// >>> testbench/scs_clock_select_checker.sv
// port assertions for the clock select block
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_clock_select_checker #(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        ext_osc_running,
  input wire logic        int_osc_enable,
  input wire logic        ext_osc_enable,
  input wire logic [2:0]  ext_osc_mode,
  input wire logic        sysclk_use_external,
  input wire logic        periph_ext_clock_enable,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] run_cnt_ff;
  logic [31:0] nxt_run_cnt;
  // ************
  // pad run time
  // ************
  // saturating count of cycles the pad has run while enabled
  always_comb begin
    nxt_run_cnt = 32'h0000_0000;
    if (ext_osc_enable && ext_osc_running) begin
      nxt_run_cnt = (run_cnt_ff == 32'hFFFF_FFFF) ? run_cnt_ff : run_cnt_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge aclk) begin
    run_cnt_ff <= aresetn ? nxt_run_cnt : 32'h0000_0000;
  end
  a_sel_needs_valid: assert property ($rose(sysclk_use_external) |-> $past(periph_ext_clock_enable))
    else $error("external selected before it was valid");
  a_fall_to_int: assert property ($fell(sysclk_use_external) |-> $past(int_osc_enable))
    else $error("fell back to a disabled internal source");
  a_ext_en_mode: assert property (ext_osc_enable == (ext_osc_mode != 3'h0))
    else $error("external enable disagrees with mode");
  a_int_en_write: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[0] && s_axi_awaddr == `SCS_OFF_INT_OSC |=> int_osc_enable == $past(s_axi_wdata[7]))
    else $error("internal enable not taken from bit seven");
  a_valid_off_zero: assert property (ce && !ext_osc_enable |=> !periph_ext_clock_enable)
    else $error("valid flag high while disabled");
  a_crystal_settle: assert property ($rose(periph_ext_clock_enable)
    && ext_osc_mode inside {scs_pkg::SCS_EXT_CRYSTAL, scs_pkg::SCS_EXT_RESON} |-> run_cnt_ff >= SETTLE_CYCLES)
    else $error("crystal valid before settle time");
  a_rc_fast: assert property ((ce && ext_osc_running && ext_osc_enable
    && ext_osc_mode inside {scs_pkg::SCS_EXT_RC, scs_pkg::SCS_EXT_CAP})[*5] |-> periph_ext_clock_enable)
    else $error("rc source not valid at once");
  a_b_after_write: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_after_ar: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  c_switch: cover property ($rose(sysclk_use_external));
  c_irq: cover property ($rose(irq));
  c_xtal: cover property ($rose(periph_ext_clock_enable) && ext_osc_mode == scs_pkg::SCS_EXT_CRYSTAL);
endmodule : scs_clock_select_checker

bind scs_clock_select scs_clock_select_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .ext_osc_running(ext_osc_running),
  .int_osc_enable(int_osc_enable), .ext_osc_enable(ext_osc_enable), .ext_osc_mode(ext_osc_mode),
  .sysclk_use_external(sysclk_use_external), .periph_ext_clock_enable(periph_ext_clock_enable), .irq(irq));

// >>> testbench/scs_osc_model.sv
// external oscillator pad model: starts after enable, crystals take longer
`timescale 1ns/100ps
module scs_osc_model #(
  parameter int unsigned XTAL_START = 12
) (
  input  wire logic       aclk,
  input  wire logic       enable,
  input  wire logic [2:0] mode,
  output logic            running
);
  int unsigned cnt_ff;
  // a crystal or resonator needs start-up; rc, capacitor and cmos run at once
  always_ff @(posedge aclk) begin
    if (!enable) begin
      cnt_ff  <= 0;
      running <= 1'b0;
    end else begin
      if (cnt_ff < XTAL_START) cnt_ff <= cnt_ff + 1;
      running <= (mode < 3'h6) || (cnt_ff >= XTAL_START);
    end
  end
endmodule : scs_osc_model

// >>> testbench/test_system_clock_select.sv
// self-checking bench for the clock select block
`timescale 1ns/100ps
`include "scs_consts.svh"
module test_system_clock_select;
  localparam int unsigned SETTLE = 8;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, running;
  logic        int_en, ext_en, use_ext, periph, irq;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  mode, freq;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
  always #2 aclk = ~aclk;
  scs_clock_select #(.SETTLE_CYCLES(SETTLE)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_osc_running(running),
    .int_osc_enable(int_en), .ext_osc_enable(ext_en), .ext_osc_mode(mode),
    .external_freq_control_bits(freq), .sysclk_use_external(use_ext),
    .periph_ext_clock_enable(periph), .irq(irq));
  scs_osc_model i_osc (.aclk(aclk), .enable(ext_en), .mode(mode), .running(running));
  // ************
  // bus tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // handshakes are sampled mid-cycle so the edge's own updates never race
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      rs    = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      v     = rdata;
      rs    = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] e);
    logic [1:0] rs;
    wr(a, {24'h00_0000, e}, rs);
    chk("bresp", 32'(rs), 32'(`SCS_RESP_OKAY));
  endtask : wr_ok
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(nm, v, {24'h00_0000, e});
  endtask : rd_chk
  // ends mid-cycle so port checks see settled values
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask : wait_cyc
  task automatic wrap_up();
    $display("TB: %0d checks, %0d mismatches", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // hang guard well above the hundred or so cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("int_rst", `SCS_OFF_INT_OSC, 8'h80);
    rd_chk("ext_rst", `SCS_OFF_EXT_OSC, 8'h00);
    rd_chk("state_rst", `SCS_OFF_STATE, 8'h04);
    $display("TB: reset test done");
    // rc circuit is usable at once, then switch and interrupt flow
    wr_ok(`SCS_OFF_EXT_OSC, 8'h43);
    wait_cyc(6);
    rd_chk("ext_rc", `SCS_OFF_EXT_OSC, 8'hC3);
    chk("freq", 32'(freq), 32'(3'h3));
    wr_ok(`SCS_OFF_CLK_SEL, 8'h01);
    wait_cyc(3);
    chk("use_ext", 32'(use_ext), 32'(1'b1));
    rd_chk("state_ext", `SCS_OFF_STATE, 8'h07);
    chk("irq_masked", 32'(irq), 32'(1'b0));
    rd_chk("status", `SCS_OFF_IRQ_STATUS, 8'h05);
    wr_ok(`SCS_OFF_IRQ_ENABLE, 8'h05);
    wait_cyc(2);
    chk("irq_on", 32'(irq), 32'(1'b1));
    wr_ok(`SCS_OFF_IRQ_CLEAR, 8'h05);
    wait_cyc(2);
    chk("irq_off", 32'(irq), 32'(1'b0));
    rd_chk("clear_wo", `SCS_OFF_IRQ_CLEAR, 8'h00);
    $display("TB: rc test done");
    // back to internal: refused while it is off, taken once enabled
    wr_ok(`SCS_OFF_INT_OSC, 8'h00);
    wr_ok(`SCS_OFF_CLK_SEL, 8'h00);
    wait_cyc(3);
    chk("int_off", 32'(int_en), 32'(1'b0));
    chk("refuse_int", 32'(use_ext), 32'(1'b1));
    wr_ok(`SCS_OFF_INT_OSC, 8'h80);
    wait_cyc(3);
    chk("sel_int", 32'(use_ext), 32'(1'b0));
    chk("periph_on", 32'(periph), 32'(1'b1));
    $display("TB: switch test done");
    // crystal: flag clear while the pad is still starting, external refused until valid
    wr_ok(`SCS_OFF_EXT_OSC, 8'h00);
    wait_cyc(2);
    chk("periph_off", 32'(periph), 32'(1'b0));
    wr_ok(`SCS_OFF_EXT_OSC, 8'hE7);
    rd_chk("xtal_early", `SCS_OFF_EXT_OSC, 8'h67);
    wr_ok(`SCS_OFF_CLK_SEL, 8'h01);
    wait_cyc(2);
    chk("refuse_ext", 32'(use_ext), 32'(1'b0));
    wait_cyc(SETTLE);
    n = 0;
    do begin
      rd(`SCS_OFF_EXT_OSC, d, r);
      n++;
    end while (d[7] !== 1'b1 && n < 40);
    chk("xtal_valid", d, 32'h0000_00E7);
    wait_cyc(3);
    chk("use_xtal", 32'(use_ext), 32'(1'b1));
    $display("TB: crystal test done");
    // unmapped place answers with an error and reads zero
    wr(8'h40, 32'h0000_0055, r);
    chk("wr_err", 32'(r), 32'(`SCS_RESP_SLVERR));
    rd(8'h40, d, r);
    chk("rd_err", 32'(r), 32'(`SCS_RESP_SLVERR));
    chk("rd_zero", d, 32'h0000_0000);
    $display("TB: unmapped test done");
    wrap_up();
  end
endmodule : test_system_clock_select
